// ---- hdl/pcsc_pkg.sv ----
package pcsc_pkg;
   localparam int          PCSC_CLK_HZ       = 125_000_000;
   localparam int          PCSC_TSU_NS       = 10_000;
   localparam int          PCSC_WD_US        = 12_800;
   localparam int          PCSC_TSU_CYC      = (PCSC_TSU_NS + 7) / 8;
   localparam int          PCSC_WD_CYC_DEF   = PCSC_WD_US * 125;
   localparam int          PCSC_CNT_W        = 21;
   localparam int          PCSC_CODE_W       = 3;
   localparam int          PCSC_MA_BASE      = 250;
   localparam int          PCSC_MA_STEP      = 25;
   // Register offsets (byte addresses)
   localparam logic [3:0]  PCSC_A_CTRL       = 4'h0;
   localparam logic [3:0]  PCSC_A_STAT       = 4'h4;
   localparam logic [3:0]  PCSC_A_CLR        = 4'h8;
   localparam logic [3:0]  PCSC_A_IEN        = 4'hC;
   // Control field positions
   localparam int          PCSC_B_PRE        = 0;
   localparam int          PCSC_B_WDF        = 1;
   localparam int          PCSC_B_CODE       = 4;
   localparam int          PCSC_B_PIN        = 8;
   localparam logic [31:0] PCSC_CTRL_RST     = 32'h0000_0002;
   localparam logic [31:0] PCSC_CTRL_MASK    = 32'h0000_0173;
   localparam logic [1:0]  PCSC_RESP_OK      = 2'b00;
   localparam logic [1:0]  PCSC_RESP_ERR     = 2'b10;
endpackage

// ---- hdl/pcsc_if.sv ----
`timescale 1ns/1ps
interface pcsc_if;
   logic                   sink_en;
   logic                   bias_preenable;
   logic                   wd_force_off_enable;
   logic [2:0]             sink_current_code;
   logic                   wd_expired_irq;
   logic                   sink_on;
   modport dev  (input sink_en, bias_preenable, wd_force_off_enable,
                 sink_current_code, output wd_expired_irq, sink_on);
   modport host (output sink_en, bias_preenable, wd_force_off_enable,
                 sink_current_code, input wd_expired_irq, sink_on);
endinterface

// ---- hdl/pcsc_sink.sv ----
`timescale 1ns/1ps
module pcsc_sink
   import pcsc_pkg::*;
#(
   parameter int WD_CYC = PCSC_WD_CYC_DEF
) (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // Link
   pcsc_if.dev              lnk,
   // Regulator side
   output logic [8:0]       sink_ma_q,
   output logic             settled_q
);
   logic                    pin_s1_q;
   logic                    pin_s2_q;
   logic                    pin_d_q;
   logic                    rise;
   logic [PCSC_CNT_W-1:0]   tsu_q;
   logic [PCSC_CNT_W-1:0]   wd_q;
   logic                    wd_run_q;
   logic                    forced_q;
   logic                    sink_on_q;
   logic                    irq_q;
   logic                    expire;

   assign lnk.sink_on        = sink_on_q;
   assign lnk.wd_expired_irq = irq_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_s1_q <= 1'b0;
         pin_s2_q <= 1'b0;
         pin_d_q  <= 1'b0;
      end else begin
         pin_s1_q <= lnk.sink_en;
         pin_s2_q <= pin_s1_q;
         pin_d_q  <= pin_s2_q;
      end
   end
   assign rise = pin_s2_q & ~pin_d_q;

   always_ff @(posedge aclk) begin
      if (!aresetn || !lnk.bias_preenable) begin
         tsu_q     <= '0;
         settled_q <= 1'b0;
      end else if (tsu_q == PCSC_CNT_W'(PCSC_TSU_CYC - 1)) begin
         settled_q <= 1'b1;
      end else begin
         tsu_q <= tsu_q + 1'b1;
      end
   end

   assign expire = wd_run_q && pin_s2_q && wd_q == PCSC_CNT_W'(WD_CYC);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wd_q     <= '0;
         wd_run_q <= 1'b0;
      end else if (rise) begin
         wd_q     <= '0;
         wd_run_q <= 1'b1;
      end else if (!pin_s2_q || expire) begin
         wd_run_q <= 1'b0;
      end else if (wd_run_q) begin
         wd_q <= wd_q + 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         irq_q <= 1'b0;
      else
         irq_q <= expire;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || rise)
         forced_q <= 1'b0;
      else if (expire && lnk.wd_force_off_enable)
         forced_q <= 1'b1;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         sink_on_q <= 1'b0;
      else
         sink_on_q <= lnk.bias_preenable && settled_q && pin_s2_q
                      && !forced_q
                      && !(expire && lnk.wd_force_off_enable);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         sink_ma_q <= 9'(PCSC_MA_BASE);
      else
         sink_ma_q <= 9'(PCSC_MA_BASE)
                      + 9'(lnk.sink_current_code) * 9'(PCSC_MA_STEP);
   end
endmodule

// ---- hdl/pcsc_host.sv ----
`timescale 1ns/1ps
module pcsc_host
   import pcsc_pkg::*;
(
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write
   input  wire logic [3:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // AXI4-Lite read
   input  wire logic [3:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // Interrupt
   output logic             irq,
   // Link
   pcsc_if.host             lnk
);
   logic [31:0]             ctrl_q;
   logic                    stat_q;
   logic                    ien_q;
   logic                    aw_q;
   logic                    w_q;
   logic [3:0]              wa_q;
   logic [31:0]             wd_q;
   logic                    do_wr;
   logic                    clr;
   logic                    irq_s1_q;
   logic                    irq_s2_q;
   logic                    aw_d;
   logic                    w_d;
   logic                    bvalid_d;
   logic                    rvalid_d;

   // Next states, so the readies can come from flops
   assign do_wr    = aw_q && w_q && !bvalid;
   assign aw_d     = !do_wr && (aw_q || (awvalid && awready));
   assign w_d      = !do_wr && (w_q || (wvalid && wready));
   assign bvalid_d = do_wr || (bvalid && !bready);
   assign rvalid_d = (arvalid && arready) || (rvalid && !rready);
   assign clr      = do_wr && wa_q == PCSC_A_CLR && wd_q[0];

   // Readies low while a transfer or an answer is pending
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b0;
         wready  <= 1'b0;
         arready <= 1'b0;
      end else begin
         awready <= !aw_d && !bvalid_d;
         wready  <= !w_d && !bvalid_d;
         arready <= !rvalid_d;
      end
   end

   // Sink-side control lines; pin line is a plain control bit
   assign lnk.bias_preenable      = ctrl_q[PCSC_B_PRE];
   assign lnk.wd_force_off_enable = ctrl_q[PCSC_B_WDF];
   assign lnk.sink_current_code   = ctrl_q[PCSC_B_CODE +: PCSC_CODE_W];
   assign lnk.sink_en             = ctrl_q[PCSC_B_PIN];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q   <= 1'b0;
         w_q    <= 1'b0;
         wa_q   <= '0;
         wd_q   <= '0;
         bvalid <= 1'b0;
         bresp  <= PCSC_RESP_OK;
      end else begin
         if (awvalid && awready) begin
            aw_q <= 1'b1;
            wa_q <= awaddr;
         end
         if (wvalid && wready) begin
            w_q  <= 1'b1;
            wd_q <= wdata;
         end
         if (do_wr) begin
            aw_q   <= 1'b0;
            w_q    <= 1'b0;
            bvalid <= 1'b1;
            bresp  <= (wa_q == PCSC_A_CTRL || wa_q == PCSC_A_CLR
                       || wa_q == PCSC_A_IEN) ? PCSC_RESP_OK
                                              : PCSC_RESP_ERR;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= PCSC_CTRL_RST;
         ien_q  <= 1'b0;
      end else if (do_wr && wa_q == PCSC_A_CTRL) begin
         ctrl_q <= wd_q & PCSC_CTRL_MASK;
      end else if (do_wr && wa_q == PCSC_A_IEN) begin
         ien_q <= wd_q[0];
      end
   end

   // Set wins over a simultaneous clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_s1_q <= 1'b0;
         irq_s2_q <= 1'b0;
         stat_q   <= 1'b0;
         irq      <= 1'b0;
      end else begin
         irq_s1_q <= lnk.wd_expired_irq;
         irq_s2_q <= irq_s1_q;
         if (irq_s2_q)
            stat_q <= 1'b1;
         else if (clr)
            stat_q <= 1'b0;
         irq <= stat_q && ien_q;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata  <= '0;
         rresp  <= PCSC_RESP_OK;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rresp  <= PCSC_RESP_OK;
         case (araddr)
            PCSC_A_CTRL: rdata <= ctrl_q;
            PCSC_A_STAT: rdata <= {30'h0000_0000, lnk.sink_on, stat_q};
            PCSC_A_IEN:  rdata <= {31'h0000_0000, ien_q};
            PCSC_A_CLR:  rdata <= '0;
            default: begin
               rdata <= '0;
               rresp <= PCSC_RESP_ERR;
            end
         endcase
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end
   end
endmodule

// ---- testbench/pcsc_asserts.sv ----
`timescale 1ns/1ps
module pcsc_asserts #(
   parameter int WD_CYC = 200
) (
   // Clock and reset
   input wire logic       aclk,
   input wire logic       aresetn,
   // Link
   input wire logic       sink_en,
   input wire logic       bias_preenable,
   input wire logic       wd_force_off_enable,
   input wire logic [2:0] sink_current_code,
   input wire logic       wd_expired_irq,
   input wire logic       sink_on
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   int hi_q;
   int pre_q;
   // Raw pin high time, restarts on every low
   always_ff @(posedge aclk) begin
      if (!aresetn || !sink_en) hi_q <= 0;
      else hi_q <= hi_q + 1;
   end
   // Saturates so it never wraps in long runs
   always_ff @(posedge aclk) begin
      if (!aresetn || !bias_preenable) pre_q <= 0;
      else if (pre_q < 2000) pre_q <= pre_q + 1;
   end
   property p_nopre; !bias_preenable [*4] |-> !sink_on; endproperty
   a_nopre: assert property (p_nopre)
      else $error("sink on, no bias");
   property p_rise;
      $rose(sink_en) && pre_q > 1300 |-> ##[1:5] sink_on;
   endproperty
   a_rise: assert property (p_rise)
      else $error("sink not on");
   property p_fall; $fell(sink_en) |-> ##[1:5] !sink_on; endproperty
   a_fall: assert property (p_fall)
      else $error("sink not off");
   property p_pulse; wd_expired_irq |=> !wd_expired_irq; endproperty
   a_pulse: assert property (p_pulse)
      else $error("long flag");
   property p_wd;
      wd_expired_irq |-> hi_q > WD_CYC && hi_q <= WD_CYC + 8;
   endproperty
   a_wd: assert property (p_wd)
      else $error("expiry time");
   property p_force;
      wd_expired_irq && wd_force_off_enable |-> !sink_on;
   endproperty
   a_force: assert property (p_force)
      else $error("not forced");
   property p_stay; !sink_on && hi_q > 8 |=> !sink_on; endproperty
   a_stay: assert property (p_stay)
      else $error("early rearm");
   property p_keep;
      wd_expired_irq && !wd_force_off_enable |-> sink_on ##1 sink_on;
   endproperty
   a_keep: assert property (p_keep)
      else $error("sink dropped");
   c_force: cover property (wd_expired_irq && wd_force_off_enable);
   c_keep: cover property (wd_expired_irq && !wd_force_off_enable);
   c_on: cover property ($rose(sink_on));
endmodule

// ---- testbench/pcsc_bench.sv ----
`timescale 1ns/1ps
module pcsc_bench;
   import pcsc_pkg::*;
   localparam int WD = 200;
   logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
   logic        arvalid = 0, rready = 0, awready, wready, bvalid, arready;
   logic        rvalid, irq, settled;
   logic [3:0]  awaddr = 0, araddr = 0, wstrb = 4'hF;
   logic [31:0] wdata = 0, rdata, rd;
   logic [1:0]  bresp, rresp, rs, bs;
   logic [8:0]  ma;
   logic [8:0]  ma_tab [8] = '{250, 275, 300, 325, 350, 375, 400, 425};
   int          err_total = 0, compares = 0, cyc = 0;
   pcsc_if lnk();
   pcsc_host i_pcsc_host (.aclk, .aresetn, .awaddr, .awvalid, .awready,
      .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
      .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .irq, .lnk);
   pcsc_sink #(.WD_CYC(WD)) i_pcsc_sink (.aclk, .aresetn, .lnk,
      .sink_ma_q(ma), .settled_q(settled));
   pcsc_asserts #(.WD_CYC(WD)) i_pcsc_asserts (.aclk, .aresetn,
      .sink_en(lnk.sink_en), .bias_preenable(lnk.bias_preenable),
      .wd_force_off_enable(lnk.wd_force_off_enable),
      .sink_current_code(lnk.sink_current_code),
      .wd_expired_irq(lnk.wd_expired_irq), .sink_on(lnk.sink_on));
   always #4 aclk = ~aclk;
   task final_report();
      if (err_total == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         final_report();
      end
   end
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         err_total++;
         $display("CHECK FAILED %s exp %h got %h", n, e, s);
      end
   endtask
   task wt(input int n);
      repeat (n) @(posedge aclk);
   endtask
   // Edge first, so back-to-back calls never reassign in one step
   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      {awvalid, wvalid, bready} <= 3'b111;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
      end while (!bvalid);
      bready <= 0;
      bs = bresp;
   endtask
   task rdw(input logic [3:0] a);
      @(posedge aclk);
      araddr <= a;
      {arvalid, rready} <= 2'b11;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 0;
      end while (!rvalid);
      rready <= 0;
      rd = rdata;
      rs = rresp;
   endtask
   function automatic logic [31:0] ctl(logic pre, logic wdf, logic [2:0] c,
                                       logic pin);
      return {23'h0, pin, 1'b0, c, 2'b0, wdf, pre};
   endfunction
   initial begin
      wt(3);
      aresetn <= 1;
      rdw(PCSC_A_CTRL);
      chk("ctrl", rd, 32'h0000_0002);
      chk("pre rst", rd[PCSC_B_PRE], 0);
      rdw(4'h2);
      chk("resp", rs, PCSC_RESP_ERR);
      wr(PCSC_A_STAT, 32'h0000_0000);
      chk("bresp", bs, PCSC_RESP_ERR);
      wr(PCSC_A_CTRL, ctl(0, 1, 0, 1));
      chk("bresp ok", bs, PCSC_RESP_OK);
      wt(20);
      chk("nopre", lnk.sink_on, 0);
      for (int i = 0; i < 8; i++) begin
         wr(PCSC_A_CTRL, ctl(1, 1, i[2:0], 0));
         wt(4);
         chk("ma", ma, ma_tab[i]);
      end
      chk("unsettled", settled, 0);
      wt(1300);
      chk("settled", settled, 1);
      wr(PCSC_A_IEN, 32'h0000_0001);
      wr(PCSC_A_CTRL, ctl(1, 1, 7, 1));
      wt(6);
      chk("on", lnk.sink_on, 1);
      wt(WD + 20);
      chk("forced", lnk.sink_on, 0);
      chk("irq", irq, 1);
      rdw(PCSC_A_STAT);
      chk("stat", rd, 32'h0000_0001);
      wr(PCSC_A_CLR, 32'h0000_0001);
      wt(4);
      chk("irqclr", irq, 0);
      wr(PCSC_A_CTRL, ctl(1, 1, 7, 0));
      wr(PCSC_A_CTRL, ctl(1, 1, 7, 1));
      wt(6);
      chk("rearm", lnk.sink_on, 1);
      for (int k = 0; k < 2; k++) begin
         wt(150);
         wr(PCSC_A_CTRL, ctl(1, 1, 7, 0));
         wr(PCSC_A_CTRL, ctl(1, 1, 7, 1));
      end
      chk("restart", irq, 0);
      wr(PCSC_A_IEN, 32'h0000_0000);
      wr(PCSC_A_CTRL, ctl(1, 0, 7, 1));
      wt(WD + 20);
      chk("kept", lnk.sink_on, 1);
      chk("masked", irq, 0);
      rdw(PCSC_A_STAT);
      chk("stat2", rd, 32'h0000_0003);
      wr(PCSC_A_IEN, 32'h0000_0001);
      wt(4);
      chk("unmask", irq, 1);
      wr(PCSC_A_CTRL, ctl(0, 0, 7, 1));
      wt(10);
      chk("bias off", lnk.sink_on, 0);
      // Mid-run reset must drop the pending flag too
      aresetn <= 0;
      wt(3);
      aresetn <= 1;
      rdw(PCSC_A_STAT);
      chk("stat rst", rd, 32'h0000_0000);
      chk("irq rst", irq, 0);
      rdw(PCSC_A_CTRL);
      chk("ctrl rst", rd, PCSC_CTRL_RST);
      chk("ma rst", ma, ma_tab[0]);
      final_report();
   end
endmodule
